// [src/pptm_down_counter.sv]
`timescale 1ns/1ps
module pptm_down_counter
    import pptm_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic start,
    input wire logic run,
    input wire logic tick,
    input wire logic single,
    input wire logic [WIDTH-1:0] load_val,
    // Status
    output logic [WIDTH-1:0] count,
    output logic tc
);

    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;

    always_comb
    begin
        tc = run && tick && (cnt_q == '0);
        cnt_d = cnt_q;
        if (start)
            cnt_d = load_val;
        else if (tc)
            cnt_d = single ? cnt_q : load_val;
        else if (run && tick)
            cnt_d = cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

    assign count = cnt_q;

endmodule

// [src/pptm_pkg.sv]
package pptm_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_SHORT_CTRL = 8'h00;
    localparam logic [7:0] OFF_SHARED_CTRL = 8'h04;
    localparam logic [7:0] OFF_LONG_CTRL = 8'h08;
    localparam logic [7:0] OFF_SHORT_HIGH = 8'h0C;
    localparam logic [7:0] OFF_SHORT_LOW = 8'h10;
    localparam logic [7:0] OFF_LONG_HIGH = 8'h14;
    localparam logic [7:0] OFF_LONG_LOW = 8'h18;
    localparam logic [7:0] OFF_COUNT = 8'h1C;

    // Field positions in the timer control registers
    localparam int BIT_ROUTE = 0;
    localparam int BIT_TMO_IE = 1;
    localparam int BIT_CAP_IE = 2;
    localparam int BIT_CLK_LO = 3;
    localparam int BIT_TMO = 5;
    localparam int BIT_SINGLE = 6;
    localparam int BIT_EN = 7;

    // Field positions in the shared control register
    localparam int BIT_LONG_INIT = 0;
    localparam int BIT_SHORT_INIT = 1;
    localparam int BIT_MODE_LO = 2;
    localparam int BIT_DEMOD = 7;

    // Mode field encodings
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_PING_PONG = 2'h3;

    // Values after reset
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] HOLD_RST = 8'h00;
    localparam logic [2:0] DIV_RST = 3'h0;

    // Timer control register layout
    typedef struct packed {
        logic       en;
        logic       single;
        logic       tmo;
        logic [1:0] clk_sel;
        logic       cap_ie;
        logic       tmo_ie;
        logic       route;
    } pptm_ctrl_t;

    // Shared control register layout
    typedef struct packed {
        logic       demod;
        logic [2:0] spare;
        logic [1:0] mode;
        logic       short_init;
        logic       long_init;
    } pptm_shared_t;

    // Divider mask for a clock select: 00 none, 01 /2, 10 /4, 11 /8
    function automatic logic [2:0] pptm_div_mask(input logic [1:0] sel);
        case (sel)
            2'h0: pptm_div_mask = 3'h0;
            2'h1: pptm_div_mask = 3'h1;
            2'h2: pptm_div_mask = 3'h3;
            default: pptm_div_mask = 3'h7;
        endcase
    endfunction

endpackage

// [src/pptm_prescale.sv]
`timescale 1ns/1ps
module pptm_prescale
    import pptm_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic clear,
    input wire logic [1:0] clk_sel,
    // Tick out
    output logic tick
);

    logic [2:0] div_q;
    logic [2:0] div_d;
    logic [2:0] mask;

    always_comb
    begin
        mask = pptm_div_mask(clk_sel);
        tick = (div_q & mask) == mask;
        div_d = clear ? DIV_RST : div_q + 3'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_q <= DIV_RST;
        else
            div_q <= div_d;
    end

endmodule

// [src/pptm_timer_pair.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Ping-pong alternation acts only in transmit mode, never in demodulation.
// - Enabling either timer starts the sequence from that timer.
// - Enabling the short timer drives its output to the shared initial level.
// - Short counter loads high or low hold by its output level.
// - Short terminal count in ping-pong disables short, enables long together.
// - Long takeover sets its initial level, loads both hold bytes, counts.
// - Long terminal count stops it and re-enables short, repeating.
// - Timeout interrupt requested only when that timer's timeout interrupt enable bit is set.
// - Writing 00 to the shared mode field ends the alternation.
// - Route bit selects port output or short timer output on pin.
// - Control bit one gates the timeout interrupt; resets to zero.
// - Control bit two gates the capture interrupt; resets to zero.
// - Clock select field divides the clock by 1, 2, 4 or 8.
// - Timeout flag reads one after timeout; writing one clears it.
// - Interrupt enables, clock select, flag survive stop-mode recovery.
// - Modulo reloads at terminal count; single-pass halts there.
module pptm_timer_pair
    import pptm_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System events
    input wire logic stop_recover,
    input wire logic capture_event,
    // Pin and timer outputs
    input wire logic port_out,
    output logic timer_output_pin,
    output logic short_counter_output,
    output logic long_counter_output,
    // Interrupt requests
    output logic short_tmo_irq,
    output logic short_cap_irq,
    output logic long_tmo_irq
);

    pptm_ctrl_t sc_q;
    pptm_ctrl_t sc_d;
    pptm_ctrl_t lc_q;
    pptm_ctrl_t lc_d;
    pptm_shared_t sh_q;
    pptm_shared_t sh_d;
    logic [7:0] short_high_hold_q;
    logic [7:0] short_high_hold_d;
    logic [7:0] short_low_hold_q;
    logic [7:0] short_low_hold_d;
    logic [7:0] long_high_hold_q;
    logic [7:0] long_high_hold_d;
    logic [7:0] long_low_hold_q;
    logic [7:0] long_low_hold_d;
    logic short_out_q;
    logic short_out_d;
    logic long_out_q;
    logic long_out_d;
    logic cap_irq_q;
    logic cap_irq_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;

    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic wr_short;
    logic wr_long;
    logic ping_pong;
    logic transmit;
    logic short_start;
    logic long_start;
    logic short_tick;
    logic long_tick;
    logic short_tc;
    logic long_tc;
    logic [7:0] short_load;
    logic [15:0] long_load;
    logic [7:0] short_count;
    logic [15:0] long_count;

    // Address decode, used by the write enable and the error answer; the read mux decodes paddr itself
    function automatic logic reg_mapped(input logic [7:0] addr);
        case (addr)
            OFF_SHORT_CTRL, OFF_SHARED_CTRL, OFF_LONG_CTRL,
            OFF_SHORT_HIGH, OFF_SHORT_LOW, OFF_LONG_HIGH,
            OFF_LONG_LOW, OFF_COUNT: reg_mapped = 1'b1;
            default: reg_mapped = 1'b0;
        endcase
    endfunction

    pptm_prescale u_short_prescale (
        .pclk(pclk),
        .presetn(presetn),
        .clear(short_start),
        .clk_sel(sc_q.clk_sel),
        .tick(short_tick)
    );

    pptm_prescale u_long_prescale (
        .pclk(pclk),
        .presetn(presetn),
        .clear(long_start),
        .clk_sel(lc_q.clk_sel),
        .tick(long_tick)
    );

    pptm_down_counter #(.WIDTH(8)) u_short_counter (
        .pclk(pclk),
        .presetn(presetn),
        .start(short_start),
        .run(sc_q.en),
        .tick(short_tick),
        .single(sc_q.single),
        .load_val(short_load),
        .count(short_count),
        .tc(short_tc)
    );

    pptm_down_counter #(.WIDTH(16)) u_long_counter (
        .pclk(pclk),
        .presetn(presetn),
        .start(long_start),
        .run(lc_q.en),
        .tick(long_tick),
        .single(lc_q.single),
        .load_val(long_load),
        .count(long_count),
        .tc(long_tc)
    );

    // Bus decode and sequencing
    always_comb
    begin
        addr_ok = reg_mapped(paddr);
        wr_en = psel && penable && pwrite && addr_ok;
        rd_setup = psel && !penable && !pwrite;
        wr_short = wr_en && (paddr == OFF_SHORT_CTRL);
        wr_long = wr_en && (paddr == OFF_LONG_CTRL);
        transmit = !sh_q.demod;
        ping_pong = transmit && (sh_q.mode == MODE_PING_PONG);
        short_start = (wr_short && pwdata[BIT_EN]) || (ping_pong && long_tc);
        long_start = (wr_long && pwdata[BIT_EN]) || (ping_pong && short_tc);
        if (short_start)
            short_load = sh_q.short_init ? short_high_hold_q : short_low_hold_q;
        else
            short_load = short_out_q ? short_low_hold_q : short_high_hold_q;
        long_load = {long_high_hold_q, long_low_hold_q};
    end

    // Register and timer state next values
    always_comb
    begin
        sc_d = sc_q;
        lc_d = lc_q;
        sh_d = sh_q;
        short_high_hold_d = short_high_hold_q;
        short_low_hold_d = short_low_hold_q;
        long_high_hold_d = long_high_hold_q;
        long_low_hold_d = long_low_hold_q;
        short_out_d = short_out_q;
        long_out_d = long_out_q;

        // Hardware stops and handovers
        if (short_tc && (sc_q.single || ping_pong))
            sc_d.en = 1'b0;
        if (long_tc && (lc_q.single || ping_pong))
            lc_d.en = 1'b0;
        if (ping_pong && long_tc)
            sc_d.en = 1'b1;
        if (ping_pong && short_tc)
            lc_d.en = 1'b1;

        // Software writes
        if (wr_short)
        begin
            sc_d.en = pwdata[BIT_EN];
            sc_d.single = pwdata[BIT_SINGLE];
            sc_d.clk_sel = pwdata[BIT_CLK_LO+1:BIT_CLK_LO];
            sc_d.cap_ie = pwdata[BIT_CAP_IE];
            sc_d.tmo_ie = pwdata[BIT_TMO_IE];
            sc_d.route = pwdata[BIT_ROUTE];
            if (pwdata[BIT_TMO])
                sc_d.tmo = 1'b0;
        end
        if (wr_long)
        begin
            lc_d = pwdata[7:0];
            lc_d.tmo = lc_q.tmo && !pwdata[BIT_TMO];
        end
        if (wr_en && (paddr == OFF_SHARED_CTRL))
            sh_d = pwdata[7:0];
        if (wr_en && (paddr == OFF_SHORT_HIGH))
            short_high_hold_d = pwdata[7:0];
        if (wr_en && (paddr == OFF_SHORT_LOW))
            short_low_hold_d = pwdata[7:0];
        if (wr_en && (paddr == OFF_LONG_HIGH))
            long_high_hold_d = pwdata[7:0];
        if (wr_en && (paddr == OFF_LONG_LOW))
            long_low_hold_d = pwdata[7:0];

        // Timeout flags: a set in the clearing cycle wins
        if (short_tc)
            sc_d.tmo = 1'b1;
        if (long_tc)
            lc_d.tmo = 1'b1;

        // Output levels toggle at terminal count in transmit mode
        if (short_start)
            short_out_d = sh_q.short_init;
        else if (short_tc && transmit)
            short_out_d = !short_out_q;
        if (long_start)
            long_out_d = sh_q.long_init;
        else if (long_tc && transmit)
            long_out_d = !long_out_q;

        // Stop-mode recovery clears enable, mode and routing only
        if (stop_recover)
        begin
            sc_d.en = 1'b0;
            sc_d.single = 1'b0;
            sc_d.route = 1'b0;
            lc_d.en = 1'b0;
            lc_d.single = 1'b0;
            lc_d.route = 1'b0;
        end

        cap_irq_d = capture_event && sc_q.cap_ie;
    end

    // Read data is captured in the setup phase
    always_comb
    begin
        prdata_d = prdata_q;
        if (rd_setup)
        begin
            case (paddr)
                OFF_SHORT_CTRL: prdata_d = {24'h000000, sc_q};
                OFF_SHARED_CTRL: prdata_d = {24'h000000, sh_q};
                OFF_LONG_CTRL: prdata_d = {24'h000000, lc_q};
                OFF_SHORT_HIGH: prdata_d = {24'h000000, short_high_hold_q};
                OFF_SHORT_LOW: prdata_d = {24'h000000, short_low_hold_q};
                OFF_LONG_HIGH: prdata_d = {24'h000000, long_high_hold_q};
                OFF_LONG_LOW: prdata_d = {24'h000000, long_low_hold_q};
                OFF_COUNT: prdata_d = {8'h00, short_count, long_count};
                default: prdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sc_q <= CTRL_RST;
            lc_q <= CTRL_RST;
            sh_q <= CTRL_RST;
            short_high_hold_q <= HOLD_RST;
            short_low_hold_q <= HOLD_RST;
            long_high_hold_q <= HOLD_RST;
            long_low_hold_q <= HOLD_RST;
            short_out_q <= 1'b0;
            long_out_q <= 1'b0;
            cap_irq_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            sc_q <= sc_d;
            lc_q <= lc_d;
            sh_q <= sh_d;
            short_high_hold_q <= short_high_hold_d;
            short_low_hold_q <= short_low_hold_d;
            long_high_hold_q <= long_high_hold_d;
            long_low_hold_q <= long_low_hold_d;
            short_out_q <= short_out_d;
            long_out_q <= long_out_d;
            cap_irq_q <= cap_irq_d;
            prdata_q <= prdata_d;
        end
    end

    // Outputs
    always_comb
    begin
        pready = 1'b1;
        pslverr = psel && penable && !addr_ok;
        prdata = prdata_q;
        timer_output_pin = sc_q.route ? short_out_q : port_out;
        short_counter_output = short_out_q;
        long_counter_output = long_out_q;
        short_tmo_irq = sc_q.tmo && sc_q.tmo_ie;
        long_tmo_irq = lc_q.tmo && lc_q.tmo_ie;
        short_cap_irq = cap_irq_q;
    end

endmodule

// [tb/pptm_timer_pair_props.sv]
`timescale 1ns/1ps
module pptm_timer_pair_props
    import pptm_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // System events
    input wire logic stop_recover,
    input wire logic capture_event,
    // Pin and timer outputs
    input wire logic port_out,
    input wire logic timer_output_pin,
    input wire logic short_counter_output,
    input wire logic long_counter_output,
    // Interrupt requests
    input wire logic short_tmo_irq,
    input wire logic short_cap_irq,
    input wire logic long_tmo_irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic acc;
    logic bad;
    assign acc = psel && penable;
    assign bad = (paddr > OFF_COUNT) || (paddr[1:0] != 2'h0);

    chk_ready_access: assert property (acc |-> pready) else $error("pready low in access");
    chk_err_unmapped: assert property (acc && bad |-> pslverr) else $error("no error on unmapped");
    chk_err_only: assert property (pslverr |-> acc && bad) else $error("spurious pslverr");
    chk_rd_unmapped: assert property (acc && !pwrite && bad |-> prdata == 32'h0) else $error("unmapped read");
    chk_rd_hold: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("prdata moved");
    chk_pin_source: assert property (timer_output_pin == port_out || timer_output_pin == short_counter_output)
        else $error("pin source");
    chk_short_flag_hold: assert property (short_tmo_irq && !(acc && pwrite && paddr == OFF_SHORT_CTRL)
        |=> short_tmo_irq) else $error("short irq dropped");
    chk_long_flag_hold: assert property (long_tmo_irq && !(acc && pwrite && paddr == OFF_LONG_CTRL)
        |=> long_tmo_irq) else $error("long irq dropped");
    chk_cap_cause: assert property (short_cap_irq |-> $past(capture_event)) else $error("capture irq");

    cover property (acc && bad);
    cover property ($rose(short_tmo_irq));
    cover property ($rose(long_tmo_irq));
    cover property (short_cap_irq);
endmodule

// [tb/pptm_timer_pair_tb.sv]
`timescale 1ns/1ps
module pptm_timer_pair_tb;
    import pptm_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic stop_recover = 1'b0;
    logic capture_event = 1'b0;
    logic port_out = 1'b0;
    logic timer_output_pin;
    logic short_counter_output;
    logic long_counter_output;
    logic short_tmo_irq;
    logic short_cap_irq;
    logic long_tmo_irq;
    int num_errors = 0;
    int samples_checked = 0;
    logic [31:0] rv;
    logic rerr;

    always #2 pclk = ~pclk;

    pptm_timer_pair pptm_timer_pair_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stop_recover(stop_recover), .capture_event(capture_event),
        .port_out(port_out), .timer_output_pin(timer_output_pin),
        .short_counter_output(short_counter_output), .long_counter_output(long_counter_output),
        .short_tmo_irq(short_tmo_irq), .short_cap_irq(short_cap_irq), .long_tmo_irq(long_tmo_irq));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            num_errors++;
            complete_run();
        end
        rv = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        check(rv, exp);
    endtask

    // Counts edges until the short output leaves its level just after the start edge
    task automatic wait_short(output int n);
        logic s;
        n = 0;
        #1;
        s = short_counter_output;
        do
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        while (short_counter_output === s && n < 300);
        if (n >= 300)
        begin
            num_errors++;
            complete_run();
        end
    endtask

    task automatic t_reset();
        rd(OFF_SHORT_CTRL, 32'h0);
        rd(OFF_SHARED_CTRL, 32'h0);
        rd(OFF_LONG_CTRL, 32'h0);
        rd(8'h20, 32'h0);
        check(rerr, 1'b1);
        @(posedge pclk);
        port_out <= 1'b1;
        capture_event <= 1'b1;
        @(posedge pclk);
        capture_event <= 1'b0;
        #1;
        check(timer_output_pin, 1'b1);
        check(short_cap_irq, 1'b0);
    endtask

    task automatic t_single();
        int n;
        logic [7:0] c;
        wr(OFF_SHORT_HIGH, 32'h5);
        wr(OFF_SHORT_LOW, 32'h3);
        for (int s = 0; s < 4; s++)
        begin
            wr(OFF_SHARED_CTRL, {30'h0, s[0], 1'b0});
            c = 8'hC0;
            c[4:3] = s[1:0];
            c[1] = s[1];
            wr(OFF_SHORT_CTRL, {24'h0, c});
            wait_short(n);
            check(n, 32'(((s[0] ? 5 : 3) + 1) << s));
            check(short_counter_output, !s[0]);
            check(short_tmo_irq, s[1]);
            c[7] = 1'b0;
            c[5] = 1'b1;
            rd(OFF_SHORT_CTRL, {24'h0, c});
            wr(OFF_SHORT_CTRL, {24'h0, c & 8'hDF});
            rd(OFF_SHORT_CTRL, {24'h0, c});
            wr(OFF_SHORT_CTRL, {24'h0, c});
            rd(OFF_SHORT_CTRL, {24'h0, c & 8'hDF});
        end
    endtask

    task automatic t_modulo();
        int n;
        wr(OFF_SHARED_CTRL, 32'h0);
        wr(OFF_SHORT_CTRL, 32'h80);
        wait_short(n);
        check(n, 32'd4);
        wait_short(n);
        check(n, 32'd6);
        rd(OFF_COUNT, 32'h00020000);
        wr(OFF_SHORT_CTRL, 32'h20);
        rd(OFF_SHORT_CTRL, 32'h0);
    endtask

    task automatic t_ping_pong();
        wr(OFF_LONG_HIGH, 32'h0);
        wr(OFF_LONG_LOW, 32'h3);
        wr(OFF_LONG_CTRL, 32'h42);
        wr(OFF_SHARED_CTRL, 32'h0F);
        wr(OFF_SHORT_CTRL, 32'hC2);
        #1;
        check({short_counter_output, long_counter_output}, 2'b10);
        repeat (6) @(posedge pclk);
        #1;
        check({short_counter_output, long_counter_output, short_tmo_irq, long_tmo_irq}, 4'h6);
        repeat (4) @(posedge pclk);
        #1;
        check({short_counter_output, long_counter_output, short_tmo_irq, long_tmo_irq}, 4'hB);
        repeat (6) @(posedge pclk);
        #1;
        check({short_counter_output, long_counter_output}, 2'b01);
        wr(OFF_SHARED_CTRL, 32'h03);
        repeat (30) @(posedge pclk);
        rd(OFF_SHORT_CTRL, 32'h62);
        rd(OFF_LONG_CTRL, 32'h62);
        wr(OFF_SHORT_CTRL, 32'h20);
        wr(OFF_LONG_CTRL, 32'h20);
    endtask

    task automatic t_demod();
        wr(OFF_SHARED_CTRL, 32'h8F);
        wr(OFF_SHORT_CTRL, 32'hC0);
        repeat (20) @(posedge pclk);
        rd(OFF_LONG_CTRL, 32'h0);
        wr(OFF_SHORT_CTRL, 32'h20);
        wr(OFF_SHARED_CTRL, 32'h0);
    endtask

    task automatic t_recover();
        wr(OFF_SHORT_CTRL, 32'h57);
        @(posedge pclk);
        port_out <= ~short_counter_output;
        capture_event <= 1'b1;
        @(posedge pclk);
        capture_event <= 1'b0;
        #1;
        check(timer_output_pin, short_counter_output);
        check(short_cap_irq, 1'b1);
        @(posedge pclk);
        stop_recover <= 1'b1;
        @(posedge pclk);
        stop_recover <= 1'b0;
        rd(OFF_SHORT_CTRL, 32'h16);
    endtask

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_single();
        t_modulo();
        t_ping_pong();
        t_demod();
        t_recover();
        complete_run();
    end

    initial
    begin
        repeat (50000) @(posedge pclk);
        num_errors++;
        complete_run();
    end
endmodule

bind pptm_timer_pair pptm_timer_pair_props pptm_timer_pair_props_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stop_recover(stop_recover), .capture_event(capture_event),
    .port_out(port_out), .timer_output_pin(timer_output_pin), .short_counter_output(short_counter_output),
    .long_counter_output(long_counter_output), .short_tmo_irq(short_tmo_irq),
    .short_cap_irq(short_cap_irq), .long_tmo_irq(long_tmo_irq));
